// >>> hdl/iep_regs.v
// How it works
// R1: enable bit one passes request, zero blocks
// R2: unimplemented bits read zero, ignore writes
// R3: enable bits read/write, reset to zero
// R4: priority fields read/write, reset to 100
// R5: field 001..111 means level 1..7
// R6: field 000 disables source despite enable
// R7: first priority register: timer1, compare1, capture1, ext0
// R8: second priority register: timer2, compare2, capture2, dma0
// R9: enable0 bits 2..0: compare1, capture1, ext0
// R10: enable1 bits 15..8 per listed sources
// R11: enable1 bits 7..0, bit 2 unimplemented
// R12: enable2 bits 15..8, bit 13 unimplemented
// R13: enable2 bits 7..0 per listed sources
// R14: enable3 bit 13, bits 8..0 implemented
// R15: enable4 bits 7..4, 2, 1 implemented
// R16: flag reads one after request occurred
// R17: pending needs flag, enable, nonzero level
// R18: writes act next cycle, flags untouched
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"

module iep_regs #(
    parameter AW = 8
) (
    input wire mclk, // system clock, 100 MHz
    input wire reset, // synchronous, active high
    input wire [AW-1:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output wire [1:0] s_axi_bresp, // write response
    output wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [AW-1:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output wire [31:0] s_axi_rdata, // read data
    output wire [1:0] s_axi_rresp, // read response
    output wire s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire [`IEP_NUM_SRC-1:0] srcReq, // peripheral request pulses
    output reg irq, // a request is pending
    output reg [2:0] irqLevel, // level of the winning source
    output reg [6:0] irqSource // slot of the winning source
);

    // bus side wires
    wire wrEn; // one-cycle write strobe
    wire [AW-1:0] wrAddr; // write address
    wire [31:0] wrData; // write data
    wire [3:0] wrStrb; // write byte strobes
    wire [AW-1:0] rdAddr; // read address
    reg wrHit; // write address mapped
    reg rdHit; // read address mapped
    reg [31:0] rdData; // readback value

    // register state
    wire [`IEP_NUM_SRC-1:0] enBits; // all enable registers, flattened
    wire [`IEP_NUM_SRC-1:0] flags; // all request flags, flattened
    reg [`IEP_REG_W-1:0] prio0; // first priority register
    reg [`IEP_REG_W-1:0] prio1; // second priority register

    // byte lanes of the low half word
    wire [`IEP_REG_W-1:0] laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
    wire [`IEP_REG_W-1:0] wrHalf = wrData[`IEP_REG_W-1:0];

    // implemented bits per enable/flag register
    function [`IEP_REG_W-1:0] implMask;
        input integer idx;
        begin
            case (idx)
                0: implMask = `IEP_EN0_MASK; // R9
                1: implMask = `IEP_EN1_MASK; // R10 R11
                2: implMask = `IEP_EN2_MASK; // R12 R13
                3: implMask = `IEP_EN3_MASK; // R14
                4: implMask = `IEP_EN4_MASK; // R15
                default: implMask = 16'h0000;
            endcase
        end
    endfunction

    // bus slave: handshakes and answers
    iep_axil_slave #(
        .AW(AW)
    ) u_slave (
        .mclk(mclk),
        .reset(reset),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrHit(wrHit),
        .rdAddr(rdAddr),
        .rdDataIn(rdData),
        .rdHit(rdHit)
    );

    // write address decode
    always @* begin
        if (wrAddr == `IEP_OFF_EN0) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_EN1) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_EN2) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_EN3) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_EN4) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_PRIO0) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_PRIO1) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_FLAG0) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_FLAG1) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_FLAG2) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_FLAG3) begin
            wrHit = 1'b1;
        end else if (wrAddr == `IEP_OFF_FLAG4) begin
            wrHit = 1'b1;
        end else begin // unmapped: error answer, nothing stored
            wrHit = 1'b0;
        end
    end

    // per-register enable and flag logic
    genvar r;
    generate
        for (r = 0; r < `IEP_NUM_EN; r = r + 1) begin : g_reg
            localparam integer EN_SUM = `IEP_OFF_EN0 + 4 * r; // enable offset, full width
            localparam integer FL_SUM = `IEP_OFF_FLAG0 + 4 * r; // flag offset, full width
            localparam [AW-1:0] EN_OFF = EN_SUM[AW-1:0]; // enable offset
            localparam [AW-1:0] FL_OFF = FL_SUM[AW-1:0]; // flag offset
            reg [`IEP_REG_W-1:0] enReg; // this register's enable bits
            reg [`IEP_REG_W-1:0] flReg; // this register's request flags
            wire [`IEP_REG_W-1:0] impl = implMask(r); // implemented bits
            wire enWr = wrEn && (wrAddr == EN_OFF); // enable write strobe
            wire flWr = wrEn && (wrAddr == FL_OFF); // flag clear strobe
            wire [`IEP_REG_W-1:0] clrBits = flWr ? (wrHalf & laneMask) : 16'h0000;
            wire [`IEP_REG_W-1:0] setBits = srcReq[16*r +: 16];

            // one driver per slice of the flattened vectors
            assign enBits[16*r +: 16] = enReg;
            assign flags[16*r +: 16] = flReg;

            // enable register: byte-lane write, unimplemented bits held zero
            always @(posedge mclk) begin
                if (reset) begin
                    enReg <= `IEP_EN_RESET; // R3
                end else if (enWr) begin // takes effect next cycle
                    enReg <= ((enReg & ~laneMask)
                        | (wrHalf & laneMask)) & impl; // R2 R3 R18
                end
            end

            // flags: sticky, write one to clear, new request wins
            always @(posedge mclk) begin
                if (reset) begin
                    flReg <= `IEP_FLAG_RESET;
                end else begin
                    flReg <= ((flReg & ~clrBits)
                        | setBits) & impl; // R16 R18
                end
            end
        end
    endgenerate

    // priority registers: fields only, gaps held zero
    always @(posedge mclk) begin
        if (reset) begin
            prio0 <= `IEP_PRIO_RESET; // R4
            prio1 <= `IEP_PRIO_RESET; // R4
        end else if (wrEn) begin
            if (wrAddr == `IEP_OFF_PRIO0) begin // timer1..ext0 fields
                prio0 <= ((prio0 & ~laneMask) | (wrHalf & laneMask))
                    & `IEP_PRIO_MASK; // R2 R4 R7
            end
            if (wrAddr == `IEP_OFF_PRIO1) begin // timer2..dma0 fields
                prio1 <= ((prio1 & ~laneMask) | (wrHalf & laneMask))
                    & `IEP_PRIO_MASK; // R2 R4 R8
            end
        end
    end

    // readback mux, zero-extended to 32 bits
    always @* begin
        rdHit = 1'b1;
        if (rdAddr == `IEP_OFF_EN0) begin
            rdData = {16'h0000, enBits[15:0]};
        end else if (rdAddr == `IEP_OFF_EN1) begin
            rdData = {16'h0000, enBits[31:16]};
        end else if (rdAddr == `IEP_OFF_EN2) begin
            rdData = {16'h0000, enBits[47:32]};
        end else if (rdAddr == `IEP_OFF_EN3) begin
            rdData = {16'h0000, enBits[63:48]};
        end else if (rdAddr == `IEP_OFF_EN4) begin
            rdData = {16'h0000, enBits[79:64]};
        end else if (rdAddr == `IEP_OFF_PRIO0) begin
            rdData = {16'h0000, prio0};
        end else if (rdAddr == `IEP_OFF_PRIO1) begin
            rdData = {16'h0000, prio1};
        end else if (rdAddr == `IEP_OFF_FLAG0) begin
            rdData = {16'h0000, flags[15:0]}; // R16
        end else if (rdAddr == `IEP_OFF_FLAG1) begin
            rdData = {16'h0000, flags[31:16]};
        end else if (rdAddr == `IEP_OFF_FLAG2) begin
            rdData = {16'h0000, flags[47:32]};
        end else if (rdAddr == `IEP_OFF_FLAG3) begin
            rdData = {16'h0000, flags[63:48]};
        end else if (rdAddr == `IEP_OFF_FLAG4) begin
            rdData = {16'h0000, flags[79:64]};
        end else begin // unmapped: zero data, error answer
            rdData = 32'h00000000;
            rdHit = 1'b0;
        end
    end

    // level of one slot: first eight slots from the fields
    function [2:0] slotLevel;
        input integer idx;
        input [`IEP_REG_W-1:0] p0;
        input [`IEP_REG_W-1:0] p1;
        begin
            if (idx < 4) begin // R7
                slotLevel = p0[`IEP_FIELD_STRIDE*idx +: `IEP_FIELD_W];
            end else if (idx < 8) begin // R8
                slotLevel = p1[`IEP_FIELD_STRIDE*(idx-4) +: `IEP_FIELD_W];
            end else begin // fields outside this block: fixed level
                slotLevel = `IEP_PRIO_OTHER;
            end
        end
    endfunction

    // arbitration: highest level wins, lowest slot breaks ties
    reg [2:0] bestLvl; // winning level so far
    reg [6:0] bestId; // winning slot so far
    reg [2:0] lvl; // level of slot under test
    integer i;
    always @* begin
        bestLvl = `IEP_PRIO_OFF;
        bestId = 7'h00;
        lvl = `IEP_PRIO_OFF;
        for (i = 0; i < `IEP_NUM_SRC; i = i + 1) begin
            lvl = slotLevel(i, prio0, prio1); // R5
            // zero level never beats the zero start value
            if (flags[i] && enBits[i] && (lvl > bestLvl)) begin // R1 R6 R17
                bestLvl = lvl;
                bestId = i[6:0];
            end
        end
    end

    // registered request to the core
    always @(posedge mclk) begin
        if (reset) begin
            irq <= 1'b0;
            irqLevel <= `IEP_PRIO_OFF;
            irqSource <= 7'h00;
        end else begin
            irq <= (bestLvl != `IEP_PRIO_OFF); // R17
            irqLevel <= bestLvl; // R5
            irqSource <= bestId;
        end
    end

endmodule // iep_regs

`default_nettype wire

// >>> hdl/iep_consts.vh
`ifndef IEP_CONSTS_VH
`define IEP_CONSTS_VH

// register byte offsets on the bus
`define IEP_OFF_EN0 8'h00
`define IEP_OFF_EN1 8'h04
`define IEP_OFF_EN2 8'h08
`define IEP_OFF_EN3 8'h0C
`define IEP_OFF_EN4 8'h10
`define IEP_OFF_PRIO0 8'h14
`define IEP_OFF_PRIO1 8'h18
`define IEP_OFF_FLAG0 8'h20
`define IEP_OFF_FLAG1 8'h24
`define IEP_OFF_FLAG2 8'h28
`define IEP_OFF_FLAG3 8'h2C
`define IEP_OFF_FLAG4 8'h30

// implemented bits of each enable and flag register
`define IEP_EN0_MASK 16'h7FFF
`define IEP_EN1_MASK 16'hFFFB
`define IEP_EN2_MASK 16'hDFFF
`define IEP_EN3_MASK 16'h21FF
`define IEP_EN4_MASK 16'h00F6

// reset values
`define IEP_EN_RESET 16'h0000
`define IEP_FLAG_RESET 16'h0000
`define IEP_PRIO_RESET 16'h4444

// priority register layout: four 3-bit fields, 4 bits apart
`define IEP_PRIO_MASK 16'h7777
`define IEP_FIELD_W 3
`define IEP_FIELD_STRIDE 4
`define IEP_PRIO_OFF 3'h0
`define IEP_PRIO_OTHER 3'h4

// source slots: five registers of sixteen bits
`define IEP_NUM_SRC 80
`define IEP_REG_W 16
`define IEP_NUM_EN 5

// bus answers
`define IEP_RESP_OKAY 2'h0
`define IEP_RESP_SLVERR 2'h2

`endif

// >>> hdl/iep_axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"

module iep_axil_slave #(
    parameter AW = 8
) (
    input wire mclk, // system clock
    input wire reset, // synchronous, active high
    input wire [AW-1:0] awaddr, // write address
    input wire awvalid, // write address valid
    output reg awready, // write address ready
    input wire [31:0] wdata, // write data
    input wire [3:0] wstrb, // byte strobes
    input wire wvalid, // write data valid
    output reg wready, // write data ready
    output reg [1:0] bresp, // write response
    output reg bvalid, // write response valid
    input wire bready, // write response ready
    input wire [AW-1:0] araddr, // read address
    input wire arvalid, // read address valid
    output reg arready, // read address ready
    output reg [31:0] rdata, // read data
    output reg [1:0] rresp, // read response
    output reg rvalid, // read data valid
    input wire rready, // read data ready
    output wire wrEn, // one-cycle register write strobe
    output reg [AW-1:0] wrAddr, // held write address
    output reg [31:0] wrData, // held write data
    output reg [3:0] wrStrb, // held byte strobes
    input wire wrHit, // write address is mapped
    output reg [AW-1:0] rdAddr, // held read address
    input wire [31:0] rdDataIn, // readback for rdAddr
    input wire rdHit // read address is mapped
);

    reg awHeld; // address captured, waiting
    reg wHeld; // data captured, waiting
    reg rdPend; // read address captured, data next

    // write fires once both halves are in and no answer is pending
    assign wrEn = awHeld & wHeld & ~bvalid;

    // write channels: address and data accepted in either order
    always @(posedge mclk) begin
        if (reset) begin
            awready <= 1'b1;
            wready <= 1'b1;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `IEP_RESP_OKAY;
            wrAddr <= {AW{1'b0}};
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
        end else begin
            if (awvalid && awready) begin // capture address
                awready <= 1'b0;
                awHeld <= 1'b1;
                wrAddr <= awaddr;
            end
            if (wvalid && wready) begin // capture data
                wready <= 1'b0;
                wHeld <= 1'b1;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            if (wrEn) begin // answer the write
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrHit ? `IEP_RESP_OKAY : `IEP_RESP_SLVERR;
            end
            if (bvalid && bready) begin // answer taken, reopen
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read channel: address, then data one cycle later
    always @(posedge mclk) begin
        if (reset) begin
            arready <= 1'b1;
            rdPend <= 1'b0;
            rvalid <= 1'b0;
            rresp <= `IEP_RESP_OKAY;
            rdata <= 32'h00000000;
            rdAddr <= {AW{1'b0}};
        end else begin
            if (arvalid && arready) begin // capture address
                arready <= 1'b0;
                rdPend <= 1'b1;
                rdAddr <= araddr;
            end
            if (rdPend) begin // present data
                rdPend <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rdHit ? rdDataIn : 32'h00000000;
                rresp <= rdHit ? `IEP_RESP_OKAY : `IEP_RESP_SLVERR;
            end
            if (rvalid && rready) begin // data taken, reopen
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule // iep_axil_slave

`default_nettype wire

// >>> bench/iep_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module iep_regs_props (
    input wire logic mclk, // clock
    input wire logic reset, // sync reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // write answer
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic irq, // pending
    input wire logic [2:0] irqLevel, // winner level
    input wire logic [6:0] irqSource // winner slot
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // both write halves taken at one edge
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    rst_quiet_a: assert property ($fell(reset) |-> !irq && irqLevel == 3'h0)
        else $error("interrupt not idle after reset");
    wr_latency_a: assert property (wrTake |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_latency_a: assert property (rdTake |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    level_nonzero_a: assert property (irq |-> irqLevel != 3'h0)
        else $error("pending at level zero");
    idle_level_a: assert property (!irq |-> irqLevel == 3'h0 && irqSource == 7'h00)
        else $error("winner shown while idle");
    source_range_a: assert property (irq |-> irqSource < 7'h50)
        else $error("winner slot out of range");
endmodule // iep_regs_props
`default_nettype wire

// >>> bench/iep_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module iep_src_model (
    input wire logic mclk, // clock
    input wire logic reset, // sync reset
    input wire logic fire, // raise one request
    input wire logic [6:0] slot, // which source
    output logic [79:0] srcReq // request lines to the block
);
    // one-cycle request pulse, lines released low otherwise
    always @(posedge mclk) begin
        if (reset || !fire) begin
            srcReq <= 80'h0;
        end else begin
            srcReq <= 80'h1 << slot;
        end
    end
endmodule // iep_src_model
`default_nettype wire

// >>> bench/iep_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"
module iep_regs_tb_top;
    logic mclk = 1'h0; // clock
    logic reset = 1'h1; // sync reset
    logic [7:0] awaddr = 8'h00, araddr = 8'h00; // addresses
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0; // write side
    logic arvalid = 1'h0, rready = 1'h0; // read side
    logic [31:0] wdata = 32'h0; // write data
    logic [3:0] wstrb = 4'h0; // strobes
    logic fire = 1'h0; // request pulse
    logic [6:0] slot = 7'h00; // request slot
    wire awready, wready, bvalid, arready, rvalid, irq; // outputs
    wire [1:0] bresp, rresp; // answers
    wire [31:0] rdata; // read data
    wire [2:0] irqLevel; // winner level
    wire [6:0] irqSource; // winner slot
    wire [79:0] srcReq; // request lines
    int errors = 0, compares = 0; // tallies
    // register offsets, implemented masks, reset values
    logic [7:0] offs [12] = '{`IEP_OFF_EN0, `IEP_OFF_EN1, `IEP_OFF_EN2, `IEP_OFF_EN3,
        `IEP_OFF_EN4, `IEP_OFF_PRIO0, `IEP_OFF_PRIO1, `IEP_OFF_FLAG0, `IEP_OFF_FLAG1,
        `IEP_OFF_FLAG2, `IEP_OFF_FLAG3, `IEP_OFF_FLAG4};
    logic [15:0] msk [7] = '{16'h7FFF, 16'hFFFB, 16'hDFFF, 16'h21FF, 16'h00F6,
        16'h7777, 16'h7777};
    logic [15:0] rv [12] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4444, 16'h4444,
        16'h0, 16'h0, 16'h0, 16'h0, 16'h0};

    always #5 mclk = ~mclk;

    iep_src_model i_src (.mclk(mclk), .reset(reset), .fire(fire), .slot(slot), .srcReq(srcReq));
    iep_regs #(.AW(8)) i_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .srcReq(srcReq), .irq(irq), .irqLevel(irqLevel),
        .irqSource(irqSource));

    // verdict and end of run
    task test_done;
        $display("counts errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // data compare
    task chkd(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // response compare
    task chkr(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // wait bound used up
    task hang;
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
        test_done;
    endtask
    // bus write; slow delays bready until bvalid seen
    task axiWr(input logic [7:0] a, input logic [15:0] d, input logic slow, output logic [1:0] r);
        int n;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        wvalid <= 1'h1;
        bready <= !slow;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'h1;
        end
        if (n == 50) hang;
        r = bresp;
        bready <= 1'h0;
    endtask
    // bus read; slow delays rready until rvalid seen
    task axiRd(input logic [7:0] a, input logic slow, output logic [31:0] d,
               output logic [1:0] r);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= !slow;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'h1;
        end
        if (n == 50) hang;
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    // one request pulse from the source model
    task pulse(input logic [6:0] s);
        @(posedge mclk);
        fire <= 1'h1;
        slot <= s;
        @(posedge mclk);
        fire <= 1'h0;
    endtask
    // let flags and winner settle, then compare
    task chkIrq(input logic i, input logic [2:0] l, input logic [6:0] s);
        repeat (4) @(posedge mclk);
        chkd({21'h0, irq, irqLevel, irqSource}, {21'h0, i, l, s});
    endtask
    // reset values of every register
    task tReset;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 12; i++) begin
            axiRd(offs[i], 1'h0, d, r);
            chkd(d, {16'h0000, rv[i]});
        end
    endtask
    // all ones then zeros through enables and priorities
    task tRw;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 7; i++) begin
            axiWr(offs[i], 16'hFFFF, 1'h0, r);
            chkr(r, `IEP_RESP_OKAY);
            axiRd(offs[i], 1'h0, d, r);
            chkd(d, {16'h0000, msk[i]});
            axiWr(offs[i], 16'h0000, 1'h0, r);
            axiRd(offs[i], 1'h0, d, r);
            chkd(d, 32'h0);
            axiWr(offs[i], rv[i], 1'h0, r);
        end
    endtask
    // unmapped address, slow answers taken
    task tBad;
        logic [31:0] d;
        logic [1:0] r;
        axiWr(8'h1C, 16'hFFFF, 1'h1, r);
        chkr(r, `IEP_RESP_SLVERR);
        axiRd(8'h1C, 1'h1, d, r);
        chkr(r, `IEP_RESP_SLVERR);
        chkd(d, 32'h0);
    endtask
    // gating, levels, arbitration, flags
    task tIrq;
        logic [31:0] d;
        logic [1:0] r;
        axiWr(`IEP_OFF_EN0, 16'h0001, 1'h0, r);
        axiWr(`IEP_OFF_PRIO0, 16'h4445, 1'h0, r);
        pulse(7'h00);
        chkIrq(1'h1, 3'h5, 7'h00);
        axiRd(`IEP_OFF_FLAG0, 1'h0, d, r);
        chkd(d, 32'h1);
        axiWr(`IEP_OFF_PRIO0, 16'h4440, 1'h0, r);
        chkIrq(1'h0, 3'h0, 7'h00);
        axiWr(`IEP_OFF_PRIO0, 16'h4475, 1'h0, r);
        axiWr(`IEP_OFF_EN0, 16'h0003, 1'h0, r);
        pulse(7'h01);
        chkIrq(1'h1, 3'h7, 7'h01);
        axiWr(`IEP_OFF_EN0, 16'h0001, 1'h0, r);
        chkIrq(1'h1, 3'h5, 7'h00);
        axiRd(`IEP_OFF_FLAG0, 1'h0, d, r);
        chkd(d, 32'h3);
        axiWr(`IEP_OFF_FLAG0, 16'h0003, 1'h0, r);
        chkIrq(1'h0, 3'h0, 7'h00);
        axiWr(`IEP_OFF_EN1, 16'hFFFF, 1'h0, r);
        pulse(7'h12);
        chkIrq(1'h0, 3'h0, 7'h00);
        axiRd(`IEP_OFF_FLAG1, 1'h0, d, r);
        chkd(d, 32'h0);
        pulse(7'h11);
        chkIrq(1'h1, 3'h4, 7'h11);
        axiWr(`IEP_OFF_FLAG1, 16'h0002, 1'h0, r);
        axiWr(`IEP_OFF_EN0, 16'h0010, 1'h0, r);
        axiWr(`IEP_OFF_PRIO1, 16'h4446, 1'h0, r);
        pulse(7'h04);
        chkIrq(1'h1, 3'h6, 7'h04);
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'h0;
        tReset;
        tRw;
        tBad;
        tIrq;
        test_done;
    end
endmodule // iep_regs_tb_top

bind iep_regs iep_regs_props i_props (.mclk, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .irq, .irqLevel, .irqSource);
`default_nettype wire
